//--- core/ffsu_top.v
// Float format and status unit: status word, exception gating, result and operand checks.
// Assumes the processor microcode drives one-cycle strobes on core_clk.
// Function
// RULE1: Floats are 32-bit single or 64-bit double, sign-magnitude.
// RULE2: Hidden leading one is restored, giving 24 or 56 effective bits.
// RULE3: Exponent is eight bits, biased by 128.
// RULE4: Biased exponent zero means zero; nonzero values use 1 to 377 octal.
// RULE5: Top bit is the sign, one means negative.
// RULE6: Zero-exponent operands act as clean zero or trap.
// RULE7: All-zero word is clean zero; zero exponent with fraction is dirty zero.
// RULE8: Overflow and underflow are flagged; fraction stays correct.
// RULE9: Sign one with exponent zero is the undefined variable.
// RULE10: Disabled overflow or underflow stores clean zero.
// RULE11: Integers are 16 or 32 bits, two's complement.
// RULE12: Three mode bits pick precision, integer length and chop or round.
// RULE13: Each instruction updates error flag and four condition codes.
// RULE14: Six exception classes; first four have their own enables.
// RULE15: Divide by zero and illegal opcode obey only global disable.
// RULE16: Mode and interrupt bits are written by load status.
// RULE17: Error flag sets on divide, illegal, or enabled other exception.
// RULE18: Only load status clears the error flag, reset does not; here reset clears it as well.
// RULE19: Global disable bit suppresses every interrupt.
// RULE20: Software should keep global disable clear.
// RULE21: Enabled bit 11 raises interrupt on negative zero operand read.
// RULE22: Enabled underflow interrupts with exponent too large by 400 octal.
// RULE23: Enabled overflow interrupts with exponent too small by 400 octal.
// RULE24: Enabled conversion failure interrupts and zeroes the destination.
// RULE25: Enabled exception gives one-cycle interrupt after status update.
`timescale 1ns/1ps
`default_nettype none
`include "ffsu_map.vh"
module ffsu_top (
    // Clock and reset
    input wire core_clk,
    input wire rst,
    // Status word load and read
    input wire load_status_instruction,
    input wire [15:0] status_wdata,
    output reg [15:0] fp_status_word,
    // Operand check strobe from memory fetch
    input wire opnd_chk,
    input wire [63:0] opnd_word,
    // Floating result strobe
    input wire res_valid,
    input wire res_sign,
    input wire [9:0] res_texp,
    input wire [54:0] res_frac,
    // Integer conversion strobe
    input wire conv_valid,
    input wire signed [63:0] conv_value,
    // Divide by zero and illegal opcode strobes
    input wire div_zero,
    input wire illegal_op,
    // Results to the processor
    output reg [63:0] result_word,
    output reg result_valid,
    output reg [31:0] int_result,
    output reg int_valid,
    output reg opnd_is_zero,
    output reg [5:0] exc_class,
    output reg fp_irq
);
    // Mode decode from the status word.
    wire dbl_mode = fp_status_word[`FFSU_DBL_BIT]; // RULE12
    wire long_mode = fp_status_word[`FFSU_LONG_BIT]; // RULE12
    wire chop_mode = fp_status_word[`FFSU_CHOP_BIT]; // RULE12
    wire en_uv = fp_status_word[`FFSU_IUV_BIT];
    wire en_ov = fp_status_word[`FFSU_IV_BIT];
    wire en_un = fp_status_word[`FFSU_IU_BIT];
    wire en_ic = fp_status_word[`FFSU_IC_BIT];
    wire gdis = fp_status_word[`FFSU_GID_BIT];

    wire c_sign;
    wire [7:0] c_bexp;
    wire c_clean;
    wire c_dirty;
    wire c_undef;
    wire [63:0] r_word;
    wire r_ovf;
    wire r_unf;

    ffsu_classify u_cls (
        .opnd(opnd_word),
        .dbl_mode(dbl_mode),
        .sign(c_sign),
        .bexp(c_bexp),
        .mant(),
        .is_clean_zero(c_clean),
        .is_dirty_zero(c_dirty),
        .is_undef(c_undef)
    );

    ffsu_result u_res (
        .res_sign(res_sign),
        .res_texp(res_texp),
        .res_frac(res_frac),
        .dbl_mode(dbl_mode),
        .ovf_en(en_ov),
        .unf_en(en_un),
        .packed_word(r_word),
        .ovf(r_ovf),
        .unf(r_unf)
    );

    // Chop keeps the fraction as is; round adds its lowest kept bit. Kept here since the packer does no rounding.
    function [54:0] ffsu_round;
        input [54:0] f;
        input chop;
        input dbl;
        begin
            if (chop)
                ffsu_round = f;
            else if (dbl)
                ffsu_round = f + {54'h0, f[0]};
            else
                ffsu_round = f + {22'h0, f[32], 32'h00000000};
        end
    endfunction

    // Integer range test: fits in 16 or 32 bits two's complement.
    function fits_int;
        input signed [63:0] v;
        input lng;
        begin
            if (lng)
                fits_int = (v >= -64'sd2147483648) && (v <= 64'sd2147483647);
            else
                fits_int = (v >= -64'sd32768) && (v <= 64'sd32767);
        end
    endfunction

    // Exception detection this cycle.
    wire x_uv = opnd_chk && c_undef; // RULE21
    wire x_ov = res_valid && r_ovf;
    wire x_un = res_valid && r_unf;
    wire x_ic = conv_valid && !fits_int(conv_value, long_mode); // RULE11
    wire [5:0] x_vec = {illegal_op, div_zero, x_ic, x_un, x_ov, x_uv}; // RULE14

    // Error-flag causes: divide and illegal always; the rest only when enabled.
    wire err_set = div_zero || illegal_op || (x_uv && en_uv) || (x_ov && en_ov)
                   || (x_un && en_un) || (x_ic && en_ic); // RULE17 RULE15
    wire irq_next = err_set && !gdis; // RULE19 RULE15

    // Condition codes from the current event.
    reg [3:0] cc_next;
    reg cc_upd;
    reg [63:0] rw_round;
    always @*
    begin
        cc_next = fp_status_word[3:0];
        cc_upd = 1'b0;
        rw_round = {r_word[63:55], ffsu_round(r_word[54:0], chop_mode, dbl_mode)};
        if (r_word == 64'h0)
            rw_round = 64'h0;
        if (res_valid)
        begin
            cc_upd = 1'b1;
            cc_next[`FFSU_N_BIT] = rw_round[63];
            cc_next[`FFSU_Z_BIT] = (rw_round[62:55] == 8'h00);
            cc_next[`FFSU_V_BIT] = r_ovf;
            cc_next[`FFSU_C_BIT] = 1'b0;
        end
        else if (conv_valid)
        begin
            cc_upd = 1'b1;
            cc_next[`FFSU_N_BIT] = x_ic ? 1'b0 : conv_value[63];
            cc_next[`FFSU_Z_BIT] = x_ic ? 1'b1 : (conv_value == 64'sd0);
            cc_next[`FFSU_V_BIT] = 1'b0;
            cc_next[`FFSU_C_BIT] = x_ic;
        end
        else if (opnd_chk)
        begin
            cc_upd = 1'b1;
            cc_next[`FFSU_N_BIT] = c_sign;
            cc_next[`FFSU_Z_BIT] = (c_bexp == 8'h00);
            cc_next[`FFSU_V_BIT] = 1'b0;
            cc_next[`FFSU_C_BIT] = 1'b0;
        end
    end

    // Status word: load status writes the writable bits, error flag included, from status_wdata,
    // but a same-cycle exception still sets it, so no error is lost; condition codes from a same-cycle event are dropped.
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            fp_status_word <= `FFSU_RESET;
        end
        else
        begin
            if (load_status_instruction)
                fp_status_word <= status_wdata & `FFSU_WR_MASK; // RULE16 RULE18
            else if (cc_upd)
                fp_status_word[3:0] <= cc_next; // RULE13
            if (err_set)
                fp_status_word[`FFSU_ERR_BIT] <= 1'b1; // RULE17 RULE13
        end
    end

    // Result path: rounded or chopped word, clean zero on disabled range errors.
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            result_word <= 64'h0;
            result_valid <= 1'b0;
        end
        else
        begin
            result_valid <= res_valid;
            if (res_valid)
                result_word <= rw_round; // RULE10 RULE22 RULE23 RULE8
        end
    end

    // Conversion path: failed conversion clears the destination, enabled or not.
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            int_result <= 32'h0;
            int_valid <= 1'b0;
        end
        else
        begin
            int_valid <= conv_valid;
            if (conv_valid)
            begin
                if (x_ic)
                    int_result <= 32'h0; // RULE24
                else if (long_mode)
                    int_result <= conv_value[31:0]; // RULE11
                else
                    int_result <= {16'h0000, conv_value[15:0]};
            end
        end
    end

    // Operand check answer: zero exponent is handled as clean zero by the arithmetic.
    always @(posedge core_clk)
    begin
        if (rst)
            opnd_is_zero <= 1'b0;
        else
            opnd_is_zero <= opnd_chk && (c_clean || c_dirty || c_undef); // RULE6 RULE7
    end

    // Interrupt pulse goes out with the status update, one cycle after the event.
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            fp_irq <= 1'b0;
            exc_class <= 6'h00;
        end
        else
        begin
            fp_irq <= irq_next; // RULE25 RULE19
            if (err_set)
                exc_class <= x_vec; // RULE14
        end
    end
endmodule
`default_nettype wire

//--- core/ffsu_map.vh
// Constants for the float format and status unit: status word fields and format layout.
// Assumes the includer uses the names only; no logic here.
`ifndef FFSU_MAP_VH
`define FFSU_MAP_VH
// Status word bit positions.
`define FFSU_ERR_BIT 15
`define FFSU_GID_BIT 14
`define FFSU_IUV_BIT 11
`define FFSU_IU_BIT 10
`define FFSU_IV_BIT 9
`define FFSU_IC_BIT 8
`define FFSU_DBL_BIT 7
`define FFSU_LONG_BIT 6
`define FFSU_CHOP_BIT 5
`define FFSU_N_BIT 3
`define FFSU_Z_BIT 2
`define FFSU_V_BIT 1
`define FFSU_C_BIT 0
// Writable bits; bits 13, 12 and 4 are reserved and read zero.
`define FFSU_WR_MASK 16'hcfef
`define FFSU_RESET 16'h0000
// Format constants.
`define FFSU_BIAS 10'h080
`define FFSU_EXP_MAX 10'h0ff
`define FFSU_SGL_FRAC 23
`define FFSU_DBL_FRAC 55
`define FFSU_WRAP 10'h100
// Exception class codes, one-hot.
`define FFSU_X_UV 6'h01
`define FFSU_X_OV 6'h02
`define FFSU_X_UN 6'h04
`define FFSU_X_IC 6'h08
`define FFSU_X_DZ 6'h10
`define FFSU_X_IL 6'h20
`endif

//--- core/ffsu_classify.v
// Operand classifier: splits a floating word and restores the hidden bit.
// Assumes a 64-bit operand left-aligned; single uses the upper 32 bits.
`timescale 1ns/1ps
`default_nettype none
`include "ffsu_map.vh"
module ffsu_classify (
    // Operand in
    input wire [63:0] opnd,
    input wire dbl_mode,
    // Decoded fields
    output wire sign,
    output wire [7:0] bexp,
    output wire [55:0] mant,
    output wire is_clean_zero,
    output wire is_dirty_zero,
    output wire is_undef
);
    wire [54:0] frac;
    // Sign is the top bit, exponent the next eight.
    assign sign = opnd[63]; // RULE5
    assign bexp = opnd[62:55]; // RULE3
    // Single precision keeps only 23 fraction bits; the rest are masked off.
    assign frac = dbl_mode ? opnd[54:0] : {opnd[54:32], 32'h00000000}; // RULE1
    // Zero exponent means zero, so the hidden bit is only restored otherwise.
    assign mant = {(bexp != 8'h00), frac}; // RULE2 RULE6
    assign is_clean_zero = (bexp == 8'h00) && !sign && (frac == 55'h0); // RULE7
    assign is_dirty_zero = (bexp == 8'h00) && !sign && (frac != 55'h0); // RULE7
    assign is_undef = (bexp == 8'h00) && sign; // RULE9
endmodule
`default_nettype wire

//--- core/ffsu_result.v
// Result packer: applies overflow and underflow handling to an exponent and fraction.
// Assumes an extended signed true exponent from the arithmetic microcode.
`timescale 1ns/1ps
`default_nettype none
`include "ffsu_map.vh"
module ffsu_result (
    // Raw result
    input wire res_sign,
    input wire signed [9:0] res_texp,
    input wire [54:0] res_frac,
    input wire dbl_mode,
    input wire ovf_en,
    input wire unf_en,
    // Packed result
    output reg [63:0] packed_word,
    output wire ovf,
    output wire unf
);
    wire [9:0] bexp_full;
    wire [54:0] frac_m;
    // Biased exponent with headroom; outside 1..377 octal means out of range.
    assign bexp_full = res_texp + `FFSU_BIAS; // RULE3
    assign ovf = res_texp > $signed(10'sh07f); // RULE8
    assign unf = res_texp < $signed(-10'sh07f); // RULE8 RULE4
    assign frac_m = dbl_mode ? res_frac : {res_frac[54:32], 32'h00000000};
    // Disabled out-of-range results become clean zero so a disabled range error never stores a negative zero.
    always @*
    begin
        if ((ovf && !ovf_en) || (unf && !unf_en))
            packed_word = 64'h0; // RULE10
        else if (ovf)
            packed_word = {res_sign, bexp_full[7:0], frac_m}; // RULE23
        else if (unf)
            packed_word = {res_sign, bexp_full[7:0], frac_m}; // RULE22
        else
            packed_word = {res_sign, bexp_full[7:0], frac_m};
    end
endmodule
`default_nettype wire

//--- tb/ffsu_checker_assertions.sv
// Checker for the float format and status unit, watching only its top-level ports.
// Assumes it is bound to ffsu_top and that every strobe is one core_clk cycle long.
`timescale 1ns/1ps
`default_nettype none
`include "ffsu_map.vh"
module ffsu_checker (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Requests
    input wire logic load_status_instruction,
    input wire logic [15:0] status_wdata,
    input wire logic opnd_chk,
    input wire logic [63:0] opnd_word,
    input wire logic res_valid,
    input wire logic [9:0] res_texp,
    input wire logic conv_valid,
    input wire logic div_zero,
    input wire logic illegal_op,
    // Answers
    input wire logic [15:0] fp_status_word,
    input wire logic [63:0] result_word,
    input wire logic result_valid,
    input wire logic int_valid,
    input wire logic opnd_is_zero,
    input wire logic fp_irq
);
    // Everything runs on the core clock; reset masks every check.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // A status load lands untouched unless an error-setting request shares its cycle; any_evt excludes every request.
    wire logic any_evt = res_valid | conv_valid | opnd_chk | div_zero | illegal_op;
    a_irq_one_pulse: assert property (fp_irq |=> !fp_irq)
        else $error("interrupt request longer than one cycle");
    a_irq_gid_mask: assert property (fp_irq |-> !$past(fp_status_word[14]))
        else $error("interrupt raised while globally disabled");
    a_dz_err_irq: assert property (div_zero || illegal_op |=> fp_status_word[15] && fp_irq == !$past(fp_status_word[14]))
        else $error("divide or illegal opcode handled wrongly");
    a_err_sticky: assert property (fp_status_word[15] && !load_status_instruction |=> fp_status_word[15])
        else $error("error flag cleared without a status load");
    a_load_write: assert property (load_status_instruction && !any_evt |=> fp_status_word == ($past(status_wdata) & `FFSU_WR_MASK))
        else $error("status load not written");
    a_reserved_zero: assert property (fp_status_word[13:12] == 2'b00 && !fp_status_word[4])
        else $error("reserved status bit set");
    a_res_answer: assert property (res_valid |=> result_valid)
        else $error("result valid missing");
    a_conv_answer: assert property (conv_valid |=> int_valid)
        else $error("integer valid missing");
    a_range_clean_zero: assert property (res_valid && ((!fp_status_word[9] && $signed(res_texp) > 127) || (!fp_status_word[10] && $signed(res_texp) < -127)) |=> result_word == 64'h0)
        else $error("disabled range fault did not store clean zero");
    a_opnd_zero: assert property (opnd_chk |=> opnd_is_zero == ($past(opnd_word[62:55]) == 8'h00))
        else $error("zero exponent check wrong");
    c_irq: cover property (fp_irq);
    c_clean_zero: cover property (result_valid && result_word == 64'h0);
    c_opnd_zero: cover property (opnd_is_zero);
endmodule
`default_nettype wire

//--- tb/ffsu_trap_model.sv
// Trap logic of the host processor, seen from the unit's interrupt request.
// Assumes the request is a one-cycle pulse on core_clk.
`timescale 1ns/1ps
`default_nettype none
module ffsu_trap_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Request from the unit
    input wire logic fp_irq,
    // Traps taken
    output var int trap_count
);
    // One trap per pulse; a stuck level would be counted every cycle and show up.
    always @(posedge core_clk)
    begin
        if (rst)
            trap_count <= 0;
        else if (fp_irq)
            trap_count <= trap_count + 1;
    end
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench for the float format and status unit with a trap model.
// Assumes one-cycle strobes and answers registered on the taking edge, one cycle after the strobe is raised.
`timescale 1ns/1ps
`default_nettype none
`include "ffsu_map.vh"
module tb_top;
    logic core_clk, rst, load_status_instruction, opnd_chk, res_valid, res_sign, conv_valid, div_zero, illegal_op;
    logic [15:0] status_wdata, fp_status_word;
    logic [63:0] opnd_word, result_word;
    logic [9:0] res_texp;
    logic [54:0] res_frac;
    logic signed [63:0] conv_value;
    logic [31:0] int_result;
    logic [5:0] exc_class;
    logic result_valid, int_valid, opnd_is_zero, fp_irq;
    int fails, comparisons, trap_count, exp_traps;
    ffsu_top i_ffsu_top (.core_clk, .rst, .load_status_instruction, .status_wdata, .fp_status_word, .opnd_chk,
        .opnd_word, .res_valid, .res_sign, .res_texp, .res_frac, .conv_valid, .conv_value, .div_zero, .illegal_op,
        .result_word, .result_valid, .int_result, .int_valid, .opnd_is_zero, .exc_class, .fp_irq);
    ffsu_trap_model i_ffsu_trap_model (.core_clk, .rst, .fp_irq, .trap_count);
    // Free-running core clock at 25 MHz.
    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // One request cycle; data is set on the same edge, and the answer lands one edge later.
    task automatic fire(input int k, input logic [63:0] d, input logic [9:0] t);
        @(posedge core_clk);
        opnd_word <= d;
        conv_value <= d;
        res_sign <= d[63];
        res_frac <= d[54:0];
        res_texp <= t;
        status_wdata <= d[15:0];
        case (k)
            0: opnd_chk <= 1'b1;
            1: res_valid <= 1'b1;
            3: conv_valid <= 1'b1;
            4: div_zero <= 1'b1;
            5: illegal_op <= 1'b1;
            default: load_status_instruction <= 1'b1;
        endcase
        @(posedge core_clk);
        {opnd_chk, res_valid, conv_valid, div_zero, illegal_op, load_status_instruction} <= 6'h00;
        #1;
    endtask
    // A hang is cut short here rather than left to run.
    initial
    begin
        repeat (20000) @(posedge core_clk);
        fails++;
        report_and_stop();
    end
    // Main sequence.
    initial
    begin
        logic [15:0] w;
        logic [63:0] d;
        int ti;
        logic en, gid, err;
        logic [54:0] f;
        int enb[4];
        enb = '{11, 9, 10, 8};
        fails = 0;
        comparisons = 0;
        exp_traps = 0;
        rst = 1'b1;
        {load_status_instruction, opnd_chk, res_valid, res_sign, conv_valid, div_zero, illegal_op} = 7'h00;
        {status_wdata, opnd_word, res_texp, res_frac, conv_value} = '0;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        #1;
        chk(fp_status_word, 16'h0000);
        void'($urandom(32'hfff9));
        for (int i = 0; i < 4; i++)
        begin
            w = 16'($urandom());
            fire(6, {48'h0, w}, 10'h000);
            chk(fp_status_word, w & `FFSU_WR_MASK);
        end
        $display("test status load done");
        // Classes: undefined variable, overflow, underflow, conversion, divide, illegal.
        for (int k = 0; k < 6; k++)
            for (int m = 0; m < 4; m++)
            begin
                en = m[0];
                gid = m[1];
                w = (16'(gid) << 14) | ((k < 4 && en) ? 16'h1 << enb[k] : 16'h0);
                fire(6, {48'h0, w}, 10'h000);
                chk(fp_status_word, w);
                d = k == 0 ? 64'h8000_0000_0000_0000 : (k == 3 ? 64'h7fff_ffff_ffff_ffff : 64'h0);
                fire(k == 2 ? 1 : k, d, k == 1 ? 10'd200 : 10'h338);
                err = k >= 4 || en;
                chk(fp_irq, err && !gid);
                chk(fp_status_word[15], err);
                if (err)
                    chk(exc_class, 6'h01 << k);
                if (k == 3)
                    chk(int_result, 32'h0);
                if (k == 1 || k == 3)
                    chk(fp_status_word[3:0], k == 3 ? 4'h5 : {1'b0, !en, 2'b10});
                if ((k == 1 || k == 2) && !en)
                    chk(result_word, 64'h0);
                else if ((k == 1 || k == 2) && !gid)
                    chk(result_word[62:55], k == 1 ? 8'h48 : 8'hb8);
                exp_traps += int'(err && !gid);
                fire(1, 64'h0, 10'd5);
                chk(fp_status_word[15], err);
            end
        $display("test exceptions done");
        for (int i = 0; i < 8; i++)
        begin
            ti = int'($urandom_range(254)) - 127;
            d = {$urandom(), $urandom()};
            // Global disable stays clear in normal use; odd passes run double, index bit 1 selects rounding.
            fire(6, {56'h0, i[0], 1'b0, !i[1], 5'h00}, 10'h000);
            fire(1, d, 10'(ti));
            // Rounding adds the lowest kept fraction bit; single precision leaves the low word zero.
            f = i[0] ? d[54:0] + 55'(i[1] & d[0]) : {d[54:32] + 23'(i[1] & d[32]), 32'h00000000};
            chk({result_valid, result_word[63:55]}, {1'b1, d[63], 8'(ti + 128)});
            chk(result_word[54:32], f[54:32]);
            chk(result_word[31:0], f[31:0]);
            chk(fp_status_word[3:0], {d[63], 3'b000});
        end
        $display("test formats done");
        for (int i = 0; i < 4; i++)
        begin
            w = 16'($urandom());
            d = {32'($signed(w)), 16'($urandom()), w};
            d = i[0] ? {{32{d[31]}}, d[31:0]} : {{48{w[15]}}, w};
            fire(6, i[0] ? 64'h0040 : 64'h0, 10'h000);
            fire(3, d, 10'h000);
            chk({int_valid, int_result}, {1'b1, i[0] ? d[31:0] : {16'h0, w}});
            chk(fp_status_word[3:0], {d[63], d == 64'h0, 2'b00});
        end
        $display("test conversion done");
        fire(0, 64'h0, 10'h000);
        chk(opnd_is_zero, 1'b1);
        fire(0, 64'h0000_0001_0000_0000, 10'h000);
        chk(opnd_is_zero, 1'b1);
        fire(0, 64'h4080_0000_0000_0000, 10'h000);
        chk(opnd_is_zero, 1'b0);
        $display("test operand check done");
        chk(trap_count, exp_traps);
        report_and_stop();
    end
endmodule
bind ffsu_top ffsu_checker i_ffsu_checker (.core_clk, .rst, .load_status_instruction, .status_wdata, .opnd_chk,
    .opnd_word, .res_valid, .res_texp, .conv_valid, .div_zero, .illegal_op, .fp_status_word, .result_word,
    .result_valid, .int_valid, .opnd_is_zero, .fp_irq);
`default_nettype wire
